/* logic/ulm_pkg.sv */
// Package for the serial line format and modem control block.
// Assumes a classic Wishbone slave with 8-bit registers in the low byte of 32-bit words.
package ulm_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_LINE_FMT   = 8'hC3;
  localparam logic [7:0] ADDR_MODEM_CTL  = 8'hC4;
  localparam logic [7:0] ADDR_MODEM_STAT = 8'hC8;
  localparam logic [7:0] ADDR_TX_DATA    = 8'hCC;
  localparam logic [7:0] ADDR_RX_DATA    = 8'hD0;
  localparam logic [7:0] ADDR_RX_STAT    = 8'hD4;
  localparam logic [7:0] ADDR_FIFO_CTL   = 8'hD8;
  localparam logic [7:0] ADDR_BAUD_DIV   = 8'hDC;
  // Line format register fields
  localparam int LF_CHAR_LO   = 0;
  localparam int LF_STOP2     = 2;
  localparam int LF_PAR_EN    = 3;
  localparam int LF_PAR_SENSE = 4;
  localparam int LF_BAD_PAR   = 5;
  // Modem control register fields
  localparam int MC_DTR       = 0;
  localparam int MC_RTS       = 1;
  localparam int MC_AUX_ONE   = 2;
  localparam int MC_AUX_TWO   = 3;
  localparam int MC_LOOP      = 4;
  localparam int MC_MULTIDROP = 5;
  localparam int MC_POLARITY  = 6;
  localparam logic [7:0] MC_WR_MASK = 8'h7F;
  // Modem status fields
  localparam int MS_CTS = 0;
  localparam int MS_DSR = 1;
  localparam int MS_RI  = 2;
  localparam int MS_DCD = 3;
  // Receive status fields
  localparam int RS_READY   = 0;
  localparam int RS_PAR_ERR = 1;
  localparam int RS_FRM_ERR = 2;
  localparam int RS_TX_BUSY = 3;
  localparam int RS_FIFO_ON = 4;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [15:0] BAUD_RESET  = 16'h0010;
  localparam logic [3:0] BASE_LEN     = 4'h5;
  typedef enum logic [2:0] {
    ULM_IDLE   = 3'b000,
    ULM_START  = 3'b001,
    ULM_DATA   = 3'b010,
    ULM_PARITY = 3'b011,
    ULM_STOP   = 3'b100
  } ulm_state_t;
  // Data bits in a character from the two low format bits
  function automatic logic [3:0] ulm_char_len(input logic [1:0] code);
    ulm_char_len = BASE_LEN + {2'h0, code};
  endfunction : ulm_char_len
  // Parity bit that makes data plus parity odd, even, space or mark
  function automatic logic ulm_par_bit(input logic [7:0] data, input logic [3:0] len,
                                       input logic md, input logic sense);
    logic [7:0] m;
    m = data & ~(8'hFF << len);
    if (md) ulm_par_bit = sense;
    else ulm_par_bit = ^m ^ ~sense;
  endfunction : ulm_par_bit
endpackage : ulm_pkg

/* logic/ulm_tx.sv */
// Serial character transmitter, one bit per baud tick.
// Assumes a tick from the parent one cycle wide; format is sampled at the start of a character.
`timescale 1ns/1ps
module ulm_tx
  import ulm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [7:0] data,
  input  wire logic [3:0] len,
  input  wire logic       stop2,
  input  wire logic       par_en,
  input  wire logic       par_val,
  output logic            ser,
  output logic            busy,
  output logic            done
);
  ulm_state_t  st_q;
  logic [7:0]  sh_q;
  logic [3:0]  cnt_q;
  logic        par_q, en_q, s2_q;
  logic [3:0]  len_q;
  wire last_bit = (cnt_q == len_q - 4'h1);
  assign busy = (st_q != ULM_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q  <= ULM_IDLE;
      sh_q  <= 8'h00;
      cnt_q <= 4'h0;
      par_q <= 1'b0;
      en_q  <= 1'b0;
      s2_q  <= 1'b0;
      len_q <= 4'h0;
      ser   <= 1'b1;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_q)
        ULM_IDLE: begin
          ser <= 1'b1;
          if (load) begin
            sh_q  <= data;
            len_q <= len;
            s2_q  <= stop2;
            en_q  <= par_en;
            par_q <= par_val;
            st_q  <= ULM_START;
          end
        end
        ULM_START: if (tick) begin
          ser   <= 1'b0;
          cnt_q <= 4'h0;
          st_q  <= ULM_DATA;
        end
        ULM_DATA: if (tick) begin
          ser   <= sh_q[0];
          sh_q  <= sh_q >> 1;
          cnt_q <= cnt_q + 4'h1;
          if (last_bit) st_q <= en_q ? ULM_PARITY : ULM_STOP;
          if (last_bit) cnt_q <= 4'h0;
        end
        ULM_PARITY: if (tick) begin
          ser  <= par_q;
          st_q <= ULM_STOP;
        end
        ULM_STOP: if (tick) begin
          ser   <= 1'b1;
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == {3'h0, s2_q}) begin
            st_q <= ULM_IDLE;
            done <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule : ulm_tx

/* logic/ulm_top.sv */
// Line format, parity, multidrop, polarity, loopback and modem control of a serial port.
// Assumes a classic Wishbone master on REF_CLK and asynchronous line pins.
`timescale 1ns/1ps
module ulm_top
  import ulm_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             WB_ERR_O,
  input  wire logic        RXD,
  input  wire logic        CTS_N,
  input  wire logic        DSR_N,
  input  wire logic        RI_N,
  input  wire logic        DCD_N,
  output logic             TXD,
  output logic             RTS_N,
  output logic             DTR_N,
  output logic             AUX1_N,
  output logic             AUX2_N
);
  // Registers
  logic [7:0]  lf_q, mc_q, fifo_ctl_q, rx_data_q;
  logic [15:0] div_q;
  logic [15:0] bcnt_q;
  logic        rx_ready_q, rx_perr_q, rx_ferr_q;
  logic        ack_q, err_q;
  logic [31:0] dat_q;
  // Synchronisers for pins
  logic [4:0]  pin_s1_q, pin_s2_q;
  // Receiver state
  ulm_state_t  rst_q;
  logic [15:0] rcnt_q;
  logic [3:0]  rbit_q;
  logic [7:0]  rsh_q;
  logic        rpar_q;
  logic [3:0]  rlen_q;
  logic        ren_q, rmd_q, rsense_q;
  logic        txd_q, rts_q, dtr_q, aux1_q, aux2_q;
  // Transmit interface
  logic        tx_ser, tx_busy, tx_done;

  // Field decode
  wire [3:0] char_len   = ulm_char_len(lf_q[LF_CHAR_LO +: 2]);
  wire       stop2      = lf_q[LF_STOP2];
  wire       par_en     = lf_q[LF_PAR_EN];
  wire       sense      = lf_q[LF_PAR_SENSE];
  wire       bad_par    = lf_q[LF_BAD_PAR];
  wire       loop_on    = mc_q[MC_LOOP];
  wire       multidrop  = mc_q[MC_MULTIDROP];
  wire       invert     = mc_q[MC_POLARITY];

  // Bus decode
  wire       req        = WB_CYC_I & WB_STB_I & ~ack_q & ~err_q;
  wire       wr_lane    = WB_SEL_I[0];
  wire       hit_lf     = (WB_ADR_I == ADDR_LINE_FMT);
  wire       hit_mc     = (WB_ADR_I == ADDR_MODEM_CTL);
  wire       hit_ms     = (WB_ADR_I == ADDR_MODEM_STAT);
  wire       hit_tx     = (WB_ADR_I == ADDR_TX_DATA);
  wire       hit_rx     = (WB_ADR_I == ADDR_RX_DATA);
  wire       hit_rs     = (WB_ADR_I == ADDR_RX_STAT);
  wire       hit_fc     = (WB_ADR_I == ADDR_FIFO_CTL);
  wire       hit_bd     = (WB_ADR_I == ADDR_BAUD_DIV);
  wire       mapped     = hit_lf | hit_mc | hit_ms | hit_tx | hit_rx | hit_rs | hit_fc | hit_bd;
  wire       wr_ok      = req & WB_WE_I & wr_lane & mapped;
  wire       tx_load    = wr_ok & hit_tx & ~tx_busy;
  wire       rd_rx      = req & ~WB_WE_I & hit_rx;

  // Baud tick for the transmitter only; the receiver times its bits with rcnt_q
  wire       tick       = (bcnt_q == 16'h0000);

  // Transmit parity, odd/even/space/mark with optional deliberate error
  wire       tx_par     = ulm_par_bit(WB_DAT_I[7:0], char_len, multidrop, sense)
                          ^ bad_par;

  // Modem status view: pins in normal mode, control bits in loopback
  wire [3:0] pin_stat   = ~pin_s2_q[4:1];
  wire [3:0] loop_stat  = {mc_q[MC_AUX_TWO], mc_q[MC_AUX_ONE], mc_q[MC_DTR], mc_q[MC_RTS]};
  wire [3:0] modem_stat = loop_on ? loop_stat : pin_stat;

  // Receive input, polarity applied to the pin only
  wire       rx_pin     = pin_s2_q[0] ^ invert;
  wire       rx_in      = loop_on ? tx_ser : rx_pin;
  wire       fifo_on    = fifo_ctl_q[0] & ~multidrop;

  // Receiver sampling at mid bit
  wire [15:0] half_div  = {1'b0, div_q[15:1]};
  wire        rsample   = (rcnt_q == 16'h0000);
  wire [7:0]  rx_masked = rsh_q >> (4'h8 - rlen_q);
  wire        exp_par   = ulm_par_bit(rx_masked, rlen_q, rmd_q, rsense_q);
  wire        rlast     = (rbit_q == rlen_q - 4'h1);

  // Read mux
  wire [7:0] ms_byte    = {4'h0, modem_stat};
  wire [7:0] rs_byte    = {3'h0, fifo_on, tx_busy, rx_ferr_q, rx_perr_q, rx_ready_q};
  wire [7:0] rd_byte    = hit_lf ? lf_q :
                          hit_mc ? mc_q :
                          hit_ms ? ms_byte :
                          hit_rx ? rx_data_q :
                          hit_rs ? rs_byte :
                          hit_fc ? fifo_ctl_q :
                          hit_bd ? div_q[7:0] : 8'h00;

  ulm_tx u_tx (
    .clk     (REF_CLK),
    .rst     (RST),
    .tick    (tick),
    .load    (tx_load),
    .data    (WB_DAT_I[7:0]),
    .len     (char_len),
    .stop2   (stop2),
    .par_en  (par_en),
    .par_val (tx_par),
    .ser     (tx_ser),
    .busy    (tx_busy),
    .done    (tx_done)
  );

  // Bus answer: one cycle after the request, error on unmapped address
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & mapped;
      err_q <= req & ~mapped;
      dat_q <= {24'h00_0000, rd_byte};
    end
  end

  // Control registers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lf_q       <= REG_RESET;
      mc_q       <= REG_RESET;
      fifo_ctl_q <= REG_RESET;
      div_q      <= BAUD_RESET;
    end else begin
      if (wr_ok & hit_lf) lf_q <= WB_DAT_I[7:0];
      else if (tx_done & multidrop) lf_q[LF_PAR_SENSE] <= 1'b0;
      if (wr_ok & hit_mc) mc_q <= WB_DAT_I[7:0] & MC_WR_MASK;
      if (wr_ok & hit_fc) fifo_ctl_q <= WB_DAT_I[7:0];
      if (wr_ok & hit_bd) div_q <= {8'h00, WB_DAT_I[7:0]};
    end
  end

  // Baud counter
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) bcnt_q <= 16'h0000;
    else bcnt_q <= tick ? div_q : bcnt_q - 16'h0001;
  end

  // Pin synchronisers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_s1_q <= 5'h1F;
      pin_s2_q <= 5'h1F;
    end else begin
      pin_s1_q <= {DCD_N, RI_N, DSR_N, CTS_N, RXD};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Receiver
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rst_q      <= ULM_IDLE;
      rcnt_q     <= 16'h0000;
      rbit_q     <= 4'h0;
      rsh_q      <= 8'h00;
      rpar_q     <= 1'b0;
      rlen_q     <= 4'h0;
      ren_q      <= 1'b0;
      rmd_q      <= 1'b0;
      rsense_q   <= 1'b0;
      rx_data_q  <= 8'h00;
      rx_ready_q <= 1'b0;
      rx_perr_q  <= 1'b0;
      rx_ferr_q  <= 1'b0;
    end else begin
      if (rd_rx) rx_ready_q <= 1'b0;
      if (rst_q != ULM_IDLE) rcnt_q <= rsample ? div_q : rcnt_q - 16'h0001;
      unique case (rst_q)
        ULM_IDLE: if (!rx_in) begin
          rcnt_q   <= half_div;
          rlen_q   <= char_len;
          ren_q    <= par_en;
          rmd_q    <= multidrop;
          rsense_q <= multidrop ? 1'b0 : sense;
          rst_q    <= ULM_START;
        end
        ULM_START: if (rsample) begin
          rbit_q <= 4'h0;
          rst_q  <= rx_in ? ULM_IDLE : ULM_DATA;
        end
        ULM_DATA: if (rsample) begin
          rsh_q  <= {rx_in, rsh_q[7:1]};
          rbit_q <= rbit_q + 4'h1;
          if (rlast) rst_q <= ren_q ? ULM_PARITY : ULM_STOP;
        end
        ULM_PARITY: if (rsample) begin
          rpar_q <= rx_in;
          rst_q  <= ULM_STOP;
        end
        ULM_STOP: if (rsample) begin
          rx_data_q  <= rx_masked;
          rx_ready_q <= 1'b1;                                       // Set wins over read clear
          rx_perr_q  <= ren_q & (rpar_q != exp_par);
          rx_ferr_q  <= ~rx_in;
          rst_q      <= ULM_IDLE;
        end
      endcase
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      txd_q  <= 1'b1;
      rts_q  <= 1'b1;
      dtr_q  <= 1'b1;
      aux1_q <= 1'b1;
      aux2_q <= 1'b1;
    end else begin
      txd_q  <= loop_on ? 1'b1 : tx_ser ^ invert;
      rts_q  <= loop_on ? 1'b1 : ~mc_q[MC_RTS];
      dtr_q  <= loop_on ? 1'b1 : ~mc_q[MC_DTR];
      aux1_q <= 1'b1;
      aux2_q <= 1'b1;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_ERR_O = err_q;
  assign WB_DAT_O = dat_q;
  assign TXD      = txd_q;
  assign RTS_N    = rts_q;
  assign DTR_N    = dtr_q;
  assign AUX1_N   = aux1_q;
  assign AUX2_N   = aux2_q;
endmodule : ulm_top

/* verification/ulm_partner.sv */
// Remote serial device: captures frames seen on TXD and sends frames on RXD.
// Assumes a bit time of BT clocks and a line that idles at mark.
`timescale 1ns/1ps
module ulm_partner #(
  parameter int BT = 16
) (
  input  wire logic       clk,
  input  wire logic       txd,
  input  wire logic       inv,
  input  wire logic [3:0] nbits,
  output logic            rxd
);
  logic [11:0] cap = 12'hFFF;
  logic        rx_bit = 1'b1;
  logic        prev_q = 1'b1;
  int          period = 0;
  int          tcyc = 0;
  int          tlast = 0;
  // Line level follows the far end's own polarity setting
  assign rxd = rx_bit ^ inv;
  always @(posedge clk) begin
    tcyc <= tcyc + 1;
    prev_q <= txd ^ inv;
  end
  // No wait after the last sample, so a back-to-back start is not missed
  initial forever begin
    @(posedge clk iff (txd ^ inv) === 1'b0 && prev_q === 1'b1);
    period = tcyc - tlast;
    tlast = tcyc;
    cap = 12'hFFF;
    repeat (BT / 2) @(posedge clk);
    for (int k = 0; k < nbits; k++) begin
      if (k > 0) repeat (BT) @(posedge clk);
      cap[k] = txd ^ inv;
    end
  end
  task automatic send(input logic [11:0] b, input logic [3:0] n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      rx_bit <= b[k];
      repeat (BT - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_bit <= 1'b1;
  endtask : send
endmodule : ulm_partner

/* verification/ulm_top_sva.sv */
// Checker for the line format and modem control block, on top-level ports.
// Assumes a Wishbone master that holds address and direction until ack.
`timescale 1ns/1ps
module ulm_top_sva
  import ulm_pkg::*;
(
  input wire logic        REF_CLK,
  input wire logic        RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  input wire logic        TXD,
  input wire logic        RTS_N,
  input wire logic        DTR_N,
  input wire logic        AUX1_N,
  input wire logic        AUX2_N
);
  logic [7:0] mc_q;
  logic [2:0] settle_q;
  wire        wr_mc = WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADDR_MODEM_CTL;
  wire        mapped = WB_ADR_I inside {ADDR_LINE_FMT, ADDR_MODEM_CTL, ADDR_MODEM_STAT,
    ADDR_TX_DATA, ADDR_RX_DATA, ADDR_RX_STAT, ADDR_FIFO_CTL, ADDR_BAUD_DIV};
  wire        rd_ack = WB_ACK_O && !WB_WE_I;
  // Pins are registered, so relations wait for a settled control value
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mc_q <= REG_RESET;
      settle_q <= 3'h0;
    end else if (wr_mc) begin
      mc_q <= WB_DAT_I[7:0] & MC_WR_MASK;
      settle_q <= 3'h0;
    end else if (settle_q != 3'h7) begin
      settle_q <= settle_q + 3'h1;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_taken;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  endsequence
  a_answer_one_cycle: assert property (s_taken |=> WB_ACK_O != WB_ERR_O)
    else $error("no single answer one cycle after request");
  a_answer_is_pulse: assert property ((WB_ACK_O || WB_ERR_O) |=> !(WB_ACK_O || WB_ERR_O))
    else $error("answer held longer than one cycle");
  a_unmapped_err: assert property (s_taken |=> WB_ERR_O == !$past(mapped))
    else $error("error answer does not match address map");
  a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_ctl_readback: assert property (rd_ack && WB_ADR_I == ADDR_MODEM_CTL |-> WB_DAT_O[7:0] == mc_q)
    else $error("modem control readback wrong");
  a_loop_pins_high: assert property (mc_q[MC_LOOP] && settle_q >= 3'h2 |-> TXD && RTS_N && DTR_N)
    else $error("pins not idle in loopback");
  a_modem_pins: assert property (!mc_q[MC_LOOP] && settle_q >= 3'h2 |->
    RTS_N == !mc_q[MC_RTS] && DTR_N == !mc_q[MC_DTR])
    else $error("handshake pins not inverse of control");
  a_aux_inactive: assert property (AUX1_N && AUX2_N)
    else $error("auxiliary output active");
  a_loop_status: assert property (rd_ack && WB_ADR_I == ADDR_MODEM_STAT && mc_q[MC_LOOP] &&
    settle_q >= 3'h5 |-> WB_DAT_O[3:0] == {mc_q[3], mc_q[2], mc_q[0], mc_q[1]})
    else $error("loopback status not mapped from control");
endmodule : ulm_top_sva
bind ulm_top ulm_top_sva ulm_top_sva_inst (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .TXD(TXD), .RTS_N(RTS_N), .DTR_N(DTR_N), .AUX1_N(AUX1_N), .AUX2_N(AUX2_N));

/* verification/testbench.sv */
// Self-checking bench: Wishbone register tasks plus a remote serial partner.
// Assumes the bit time is divisor plus one clocks, with the divisor set to 15.
`timescale 1ns/1ps
module testbench
  import ulm_pkg::*;
;
  localparam int BT = 16;
  localparam logic [23:0] TXC [8] = '{24'h0B005A, 24'h1B005A, 24'h000013, 24'h05002A,
    24'h0E0055, 24'h2B005A, 24'h0340C3, 24'h1B2081};
  // Each entry: modem control, frame format sent by the partner, expected receive status
  localparam logic [23:0] RXC [6] = '{24'h000B01, 24'h002B03, 24'h000B05, 24'h200B01,
    24'h201B03, 24'h400B01};
  localparam logic [7:0] MCV [7] = '{8'h03, 8'h01, 8'h0E, 8'h1F, 8'h13, 8'h1C, 8'h11};
  logic        clk, rst, cyc, stb, we, ack, err, rxd, inv, e;
  logic        txd, rts_n, dtr_n, aux1_n, aux2_n;
  logic [7:0]  adr, f, m, d;
  logic [3:0]  sel, mst_n, nb;
  logic [11:0] b;
  logic [31:0] wdat, dato, q;
  int          errors, checks_done;
  ulm_top ulm_top_inst (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .WB_ERR_O(err), .RXD(rxd), .CTS_N(mst_n[0]), .DSR_N(mst_n[1]),
    .RI_N(mst_n[2]), .DCD_N(mst_n[3]), .TXD(txd), .RTS_N(rts_n), .DTR_N(dtr_n),
    .AUX1_N(aux1_n), .AUX2_N(aux2_n));
  ulm_partner #(.BT(BT)) ulm_partner_inst (.clk(clk), .txd(txd), .inv(inv), .nbits(nb),
    .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, v};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    q = dato;
    e = err;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 8'h00);
    chk(q, exp);
  endtask : rdc
  task automatic tx_char(input logic [7:0] v);
    int k;
    wb(1'b1, ADDR_TX_DATA, v);
    k = 0;
    do begin
      wb(1'b0, ADDR_RX_STAT, 8'h00);
      k++;
    end while (q[RS_TX_BUSY] !== 1'b0 && k < 400);
  endtask : tx_char
  task automatic setup(input logic [7:0] lf, input logic [7:0] mc);
    wb(1'b1, ADDR_LINE_FMT, lf);
    wb(1'b1, ADDR_MODEM_CTL, mc);
    inv <= mc[MC_POLARITY];
    repeat (200) @(posedge clk);
    wb(1'b0, ADDR_RX_DATA, 8'h00);
  endtask : setup
  // Expected frame from start bit to last stop, LSB first, idle ones above
  function automatic logic [11:0] efr(input logic [7:0] v, input logic [7:0] lf,
                                      input logic md, output logic [3:0] n);
    logic [11:0] r;
    logic        p;
    r = 12'hFFE;
    n = 4'h1;
    p = ~lf[LF_PAR_SENSE];
    for (int i = 0; i < 5 + lf[1:0]; i++) begin
      r[n] = v[i];
      p = p ^ v[i];
      n++;
    end
    if (md) p = lf[LF_PAR_SENSE];
    if (lf[LF_PAR_EN]) begin
      r[n] = p ^ lf[LF_BAD_PAR];
      n++;
    end
    n = n + 4'h1 + lf[LF_STOP2];
    return r;
  endfunction : efr
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    tally_and_finish;
  end
  initial begin
    {rst, cyc, stb, we, inv, adr, wdat, sel, mst_n, nb} = {1'b1, 44'h0, 4'h1, 4'hF, 4'hC};
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdc(ADDR_LINE_FMT, 32'h0);
    rdc(ADDR_MODEM_CTL, 32'h0);
    rdc(ADDR_BAUD_DIV, 32'h10);
    chk({txd, rts_n, dtr_n, aux1_n, aux2_n}, 32'h1F);
    wb(1'b0, 8'hE0, 8'h00);
    chk(e, 1);
    wb(1'b1, ADDR_BAUD_DIV, 8'h0F);
    foreach (MCV[i]) begin
      mst_n <= MCV[i][3:0] ^ 4'h5;
      wb(1'b1, ADDR_MODEM_CTL, MCV[i] | 8'h80);
      rdc(ADDR_MODEM_CTL, MCV[i]);
      rdc(ADDR_MODEM_STAT, MCV[i][4] ? {MCV[i][3:2], MCV[i][0], MCV[i][1]} : MCV[i][3:0] ^ 4'hA);
      chk({txd, rts_n, dtr_n, aux1_n, aux2_n}, MCV[i][4] ? 5'h1F : {1'b1, ~MCV[i][1:0], 2'b11});
    end
    foreach (TXC[i]) begin
      {f, m, d} = TXC[i];
      setup(f, m);
      for (int j = 0; j < 2; j++) begin
        b = efr(d, (j > 0 && m[MC_MULTIDROP]) ? f & 8'hEF : f, m[MC_MULTIDROP], nb);
        tx_char(d);
        chk(ulm_partner_inst.cap, b);
        if (j > 0) chk(ulm_partner_inst.period / BT - nb, 0);
      end
      rdc(ADDR_LINE_FMT, m[MC_MULTIDROP] ? f & 8'hEF : f);
    end
    foreach (RXC[i]) begin
      m = RXC[i][23:16];
      d = 8'hA5 ^ i;
      setup(m[MC_MULTIDROP] ? 8'h1B : 8'h0B, m);
      b = efr(d, RXC[i][15:8], m[MC_MULTIDROP], nb);
      if (RXC[i][2]) b[nb - 1] = 1'b0;
      ulm_partner_inst.send(b, nb);
      repeat (2 * BT) @(posedge clk);
      rdc(ADDR_RX_STAT, RXC[i][7:0]);
      rdc(ADDR_RX_DATA, d);
    end
    for (int i = 0; i < 2; i++) begin
      setup(i ? 8'h2B : 8'h0B, 8'h10);
      tx_char(8'h3C);
      repeat (2 * BT) @(posedge clk);
      rdc(ADDR_RX_STAT, i ? 32'h3 : 32'h1);
      rdc(ADDR_RX_DATA, 32'h3C);
    end
    wb(1'b1, ADDR_FIFO_CTL, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, ADDR_MODEM_CTL, i ? 8'h20 : 8'h00);
      wb(1'b0, ADDR_RX_STAT, 8'h00);
      chk(q[RS_FIFO_ON], i == 0);
    end
    tally_and_finish;
  end
endmodule : testbench
